// ===== inc/ssei_pkg.sv
// ============================================================
// Register map and field layout
package ssei_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned CH_W   = 8;

  // ============================================================
  // Byte offsets
  localparam logic [11:0] OFS_END_FLAG   = 12'h104;
  localparam logic [11:0] OFS_RXEND_FLAG = 12'h110;
  localparam logic [11:0] OFS_ACQ_FLAG   = 12'h128;
  localparam logic [11:0] OFS_END_PUB    = 12'h184;
  localparam logic [11:0] OFS_RXEND_PUB  = 12'h190;
  localparam logic [11:0] OFS_ACQ_PUB    = 12'h1a8;
  localparam logic [11:0] OFS_SHORTCUT   = 12'h200;
  localparam logic [11:0] OFS_IRQ_SET    = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR    = 12'h308;

  // ============================================================
  // Field positions
  localparam int unsigned FLAG_BIT      = 0;
  localparam int unsigned PUB_CH_LSB    = 0;
  localparam int unsigned PUB_CH_MSB    = 7;
  localparam int unsigned PUB_EN_BIT    = 31;
  localparam int unsigned SHORT_ACQ_BIT = 0;
  localparam int unsigned IRQ_END_BIT   = 0;
  localparam int unsigned IRQ_RXEND_BIT = 1;
  localparam int unsigned IRQ_ACQ_BIT   = 2;
  localparam int unsigned IRQ_N         = 3;

  // ============================================================
  // Reset values
  localparam logic [31:0] PUB_RESET   = 32'h0000_0000;
  localparam logic        FLAG_RESET  = 1'h0;
  localparam logic        SHORT_RESET = 1'h0;
  localparam logic [2:0]  IEN_RESET   = 3'h0;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

endpackage : ssei_pkg

// ===== core/ssei_regs.sv
// ============================================================
// Contract
// - Acquired event flag, readable, writable, reset zero
// - Transaction-end publish config, channel, reset zero
// - Rx-end publish config, enable gates broadcast
// - Acquired publish config gates like others
// - Shortcut bit couples end to acquire task
// - Enable-set write one enables matching interrupt
// - Enable-set read returns enable state
// - Enable-clear write one disables matching interrupt
// - Enable-clear read returns same enable state
// - Rx-end event when buffer reaches maximum
`timescale 1ns/1ns

module ssei_regs
  import ssei_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              end_event_pulse,
  input  wire logic              acquired_event_pulse,
  input  wire logic              rx_start_pulse,
  input  wire logic              rx_byte_pulse,
  input  wire logic [CNT_W-1:0]  rx_max_count,
  output logic                   acquire_task_pulse,
  output logic                   end_publish_strobe,
  output logic      [CH_W-1:0]   end_publish_channel,
  output logic                   rx_end_publish_strobe,
  output logic      [CH_W-1:0]   rx_end_publish_channel,
  output logic                   acquired_publish_strobe,
  output logic      [CH_W-1:0]   acquired_publish_channel,
  output logic                   irq
);

  // ============================================================
  // Helpers
  function automatic logic pub_fire(input logic [31:0] cfg,
                                    input logic        ev);
    pub_fire = ev & cfg[PUB_EN_BIT];
  endfunction : pub_fire

  function automatic logic [31:0] bit_word(input logic b);
    bit_word = {31'h0000_0000, b};
  endfunction : bit_word

  function automatic logic flag_next(input logic cur,
                                     input logic set,
                                     input logic wr,
                                     input logic wval);
    // Hardware set wins over a simultaneous software write
    flag_next = set | (wr ? wval : cur);
  endfunction : flag_next

  // ============================================================
  // State
  logic              end_flag_reg;
  logic              rx_end_flag_reg;
  logic              acquired_flag_reg;
  logic [31:0]       end_pub_reg;
  logic [31:0]       rx_end_pub_reg;
  logic [31:0]       acq_pub_reg;
  logic              short_reg;
  logic [IRQ_N-1:0]  ien_reg;
  logic [CNT_W-1:0]  rx_count_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              acq_task_reg;
  logic              end_pub_stb_reg;
  logic              rx_end_pub_stb_reg;
  logic              acq_pub_stb_reg;
  logic              irq_reg;

  // ============================================================
  // Address decode
  wire hit_end_flag   = (reg_addr == OFS_END_FLAG);
  wire hit_rxend_flag = (reg_addr == OFS_RXEND_FLAG);
  wire hit_acq_flag   = (reg_addr == OFS_ACQ_FLAG);
  wire hit_end_pub    = (reg_addr == OFS_END_PUB);
  wire hit_rxend_pub  = (reg_addr == OFS_RXEND_PUB);
  wire hit_acq_pub    = (reg_addr == OFS_ACQ_PUB);
  wire hit_shortcut   = (reg_addr == OFS_SHORTCUT);
  wire hit_irq_set    = (reg_addr == OFS_IRQ_SET);
  wire hit_irq_clr    = (reg_addr == OFS_IRQ_CLR);

  wire wr_end_flag    = reg_wr & hit_end_flag;
  wire wr_rxend_flag  = reg_wr & hit_rxend_flag;
  wire wr_acq_flag    = reg_wr & hit_acq_flag;
  wire wr_end_pub     = reg_wr & hit_end_pub;
  wire wr_rxend_pub   = reg_wr & hit_rxend_pub;
  wire wr_acq_pub     = reg_wr & hit_acq_pub;
  wire wr_shortcut    = reg_wr & hit_shortcut;
  wire wr_irq_set     = reg_wr & hit_irq_set;
  wire wr_irq_clr     = reg_wr & hit_irq_clr;

  wire wval = reg_wdata[FLAG_BIT];

  // ============================================================
  // Receive buffer fill tracking
  wire [CNT_W-1:0] rx_count_inc = rx_count_reg + 16'h0001;
  wire             rx_room      = (rx_count_reg < rx_max_count);
  wire             rx_take      = rx_byte_pulse & rx_room;
  wire             rx_end_event = rx_take &
                                  (rx_count_inc == rx_max_count);

  wire [CNT_W-1:0] rx_count_next =
    rx_start_pulse ? CNT_RESET :
    rx_take        ? rx_count_inc :
                     rx_count_reg;

  // ============================================================
  // Event flags
  wire end_flag_next =
    flag_next(end_flag_reg, end_event_pulse, wr_end_flag, wval);
  wire rx_end_flag_next =
    flag_next(rx_end_flag_reg, rx_end_event, wr_rxend_flag, wval);
  wire acquired_flag_next =
    flag_next(acquired_flag_reg, acquired_event_pulse,
              wr_acq_flag, wval);

  // ============================================================
  // Configuration registers
  wire [31:0] end_pub_next =
    wr_end_pub ? reg_wdata : end_pub_reg;
  wire [31:0] rx_end_pub_next =
    wr_rxend_pub ? reg_wdata : rx_end_pub_reg;
  wire [31:0] acq_pub_next =
    wr_acq_pub ? reg_wdata : acq_pub_reg;
  wire short_next =
    wr_shortcut ? reg_wdata[SHORT_ACQ_BIT] : short_reg;

  // ============================================================
  // Interrupt enables
  wire [IRQ_N-1:0] ien_set_bits =
    wr_irq_set ? reg_wdata[IRQ_N-1:0] : IEN_RESET;
  wire [IRQ_N-1:0] ien_clr_bits =
    wr_irq_clr ? reg_wdata[IRQ_N-1:0] : IEN_RESET;
  wire [IRQ_N-1:0] ien_next =
    (ien_reg | ien_set_bits) & ~ien_clr_bits;

  wire [IRQ_N-1:0] flag_vec_next;
  assign flag_vec_next[IRQ_END_BIT]   = end_flag_next;
  assign flag_vec_next[IRQ_RXEND_BIT] = rx_end_flag_next;
  assign flag_vec_next[IRQ_ACQ_BIT]   = acquired_flag_next;

  wire irq_next = |(flag_vec_next & ien_next);

  // ============================================================
  // Event outputs
  wire acq_task_next = end_event_pulse & short_reg;
  wire end_pub_stb_next =
    pub_fire(end_pub_reg, end_event_pulse);
  wire rx_end_pub_stb_next =
    pub_fire(rx_end_pub_reg, rx_end_event);
  wire acq_pub_stb_next =
    pub_fire(acq_pub_reg, acquired_event_pulse);

  // ============================================================
  // Read mux
  wire [DATA_W-1:0] ien_word = {29'h0000_0000, ien_reg};

  wire [DATA_W-1:0] rd_word =
    hit_end_flag   ? bit_word(end_flag_reg)      :
    hit_rxend_flag ? bit_word(rx_end_flag_reg)   :
    hit_acq_flag   ? bit_word(acquired_flag_reg) :
    hit_end_pub    ? end_pub_reg                 :
    hit_rxend_pub  ? rx_end_pub_reg              :
    hit_acq_pub    ? acq_pub_reg                 :
    hit_shortcut   ? bit_word(short_reg)         :
    hit_irq_set    ? ien_word                    :
    hit_irq_clr    ? ien_word                    :
                     RD_ZERO;

  wire [DATA_W-1:0] rdata_next = reg_rd ? rd_word : RD_ZERO;

  // ============================================================
  // Event flag flops
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      end_flag_reg <= FLAG_RESET;
    end else if (clk_en) begin
      end_flag_reg <= end_flag_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_end_flag_reg <= FLAG_RESET;
    end else if (clk_en) begin
      rx_end_flag_reg <= rx_end_flag_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      acquired_flag_reg <= FLAG_RESET;
    end else if (clk_en) begin
      acquired_flag_reg <= acquired_flag_next;
    end
  end

  // ============================================================
  // Configuration, interrupt enable and rx count flops
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      end_pub_reg <= PUB_RESET;
    end else if (clk_en) begin
      end_pub_reg <= end_pub_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_end_pub_reg <= PUB_RESET;
    end else if (clk_en) begin
      rx_end_pub_reg <= rx_end_pub_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      acq_pub_reg <= PUB_RESET;
    end else if (clk_en) begin
      acq_pub_reg <= acq_pub_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      short_reg <= SHORT_RESET;
    end else if (clk_en) begin
      short_reg <= short_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ien_reg <= IEN_RESET;
    end else if (clk_en) begin
      ien_reg <= ien_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_count_reg <= CNT_RESET;
    end else if (clk_en) begin
      rx_count_reg <= rx_count_next;
    end
  end

  // ============================================================
  // Output flops
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_reg <= RD_ZERO;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      acq_task_reg <= 1'h0;
    end else if (clk_en) begin
      acq_task_reg <= acq_task_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      end_pub_stb_reg <= 1'h0;
    end else if (clk_en) begin
      end_pub_stb_reg <= end_pub_stb_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_end_pub_stb_reg <= 1'h0;
    end else if (clk_en) begin
      rx_end_pub_stb_reg <= rx_end_pub_stb_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      acq_pub_stb_reg <= 1'h0;
    end else if (clk_en) begin
      acq_pub_stb_reg <= acq_pub_stb_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_reg <= 1'h0;
    end else if (clk_en) begin
      irq_reg <= irq_next;
    end
  end

  // ============================================================
  // Output drive
  assign reg_rdata               = rdata_reg;
  assign acquire_task_pulse      = acq_task_reg;
  assign end_publish_strobe      = end_pub_stb_reg;
  assign rx_end_publish_strobe   = rx_end_pub_stb_reg;
  assign acquired_publish_strobe = acq_pub_stb_reg;
  assign irq                     = irq_reg;

  assign end_publish_channel      = end_pub_reg[PUB_CH_MSB:PUB_CH_LSB];
  assign rx_end_publish_channel   =
    rx_end_pub_reg[PUB_CH_MSB:PUB_CH_LSB];
  assign acquired_publish_channel = acq_pub_reg[PUB_CH_MSB:PUB_CH_LSB];

endmodule : ssei_regs

// ===== test/ssei_regs_sva.sv
`timescale 1ns/1ns
// ============================================================
// Port checker
module ssei_regs_chk
  import ssei_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              end_event_pulse,
  input wire logic              acquired_event_pulse,
  input wire logic              rx_byte_pulse,
  input wire logic              acquire_task_pulse,
  input wire logic              end_publish_strobe,
  input wire logic              rx_end_publish_strobe,
  input wire logic              acquired_publish_strobe,
  input wire logic              irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_task_cause: assert property (
    acquire_task_pulse |-> $past(end_event_pulse))
    else $error("acquire task without end event");
  chk_end_pub: assert property (
    end_publish_strobe |-> $past(end_event_pulse))
    else $error("end publish without end event");
  chk_acq_pub: assert property (
    acquired_publish_strobe |-> $past(acquired_event_pulse))
    else $error("acquired publish without event");
  chk_rx_end_pub: assert property (
    rx_end_publish_strobe |-> $past(rx_byte_pulse))
    else $error("rx end publish without rx byte");
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  chk_unmapped_read: assert property (
    $past(reg_rd && reg_addr == 12'h0fc) |-> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_irq_rise: assert property (
    $rose(irq) |-> $past(end_event_pulse || acquired_event_pulse
                         || rx_byte_pulse || reg_wr))
    else $error("irq rose without cause");
  chk_clear_all: assert property (
    $past(reg_wr && reg_addr == OFS_IRQ_CLR && reg_wdata[2:0] == 3'h7)
    |-> !irq ##1 (!irq || $past(reg_wr && reg_addr == OFS_IRQ_SET)))
    else $error("irq after clearing all enables");
endmodule : ssei_regs_chk

bind ssei_regs ssei_regs_chk u_chk (.core_clk, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .end_event_pulse,
  .acquired_event_pulse, .rx_byte_pulse, .acquire_task_pulse,
  .end_publish_strobe, .rx_end_publish_strobe, .acquired_publish_strobe,
  .irq);

// ===== test/ssei_regs_test.sv
`timescale 1ns/1ns
// ============================================================
// Testbench
module ssei_regs_test;
  import ssei_pkg::*;
  logic        core_clk, resetn, clk_en, reg_wr, reg_rd, irq, tsk;
  logic        ev_end, ev_acq, rx_start, rx_byte, e_stb, r_stb, a_stb;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] rx_max;
  logic [7:0]  e_ch, r_ch, a_ch;
  int          num_errors, checks_done, cycles;
  logic [11:0] ofs [9] = '{OFS_END_FLAG, OFS_RXEND_FLAG, OFS_ACQ_FLAG,
    OFS_END_PUB, OFS_RXEND_PUB, OFS_ACQ_PUB, OFS_SHORTCUT, OFS_IRQ_SET,
    OFS_IRQ_CLR};

  ssei_regs dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .end_event_pulse(ev_end),
    .acquired_event_pulse(ev_acq), .rx_start_pulse(rx_start),
    .rx_byte_pulse(rx_byte), .rx_max_count(rx_max),
    .acquire_task_pulse(tsk), .end_publish_strobe(e_stb),
    .end_publish_channel(e_ch), .rx_end_publish_strobe(r_stb),
    .rx_end_publish_channel(r_ch), .acquired_publish_strobe(a_stb),
    .acquired_publish_channel(a_ch), .irq(irq));

  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end

  task conclude();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    #1;
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 chk("rdata", e, reg_rdata);
  endtask : rd

  task ev(input logic [3:0] m);
    @(posedge core_clk);
    {ev_end, ev_acq, rx_start, rx_byte} <= m;
    @(posedge core_clk);
    {ev_end, ev_acq, rx_start, rx_byte} <= 4'h0;
    #1;
  endtask : ev

  task t_regs();
    foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
    wr(OFS_ACQ_FLAG, 32'h1);
    rd(OFS_ACQ_FLAG, 32'h1);
    wr(OFS_ACQ_FLAG, 32'h0);
    rd(OFS_ACQ_FLAG, 32'h0);
    wr(OFS_END_PUB, 32'h8000_00a5);
    rd(OFS_END_PUB, 32'h8000_00a5);
    wr(OFS_ACQ_PUB, 32'h0000_0042);
    rd(OFS_ACQ_PUB, 32'h0000_0042);
    wr(12'h0fc, 32'hffff_ffff);
    rd(12'h0fc, 32'h0000_0000);
  endtask : t_regs

  task t_hold();
    @(posedge core_clk);
    clk_en <= 1'h0;
    wr(OFS_IRQ_SET, 32'h7);
    ev(4'h8);
    chk("end strobe", 1'h0, e_stb);
    chk("irq", 1'h0, irq);
    @(posedge core_clk);
    clk_en <= 1'h1;
    rd(OFS_IRQ_SET, 32'h0);
    rd(OFS_END_FLAG, 32'h0);
  endtask : t_hold

  task t_ien();
    wr(OFS_IRQ_SET, 32'h7);
    rd(OFS_IRQ_SET, 32'h7);
    rd(OFS_IRQ_CLR, 32'h7);
    wr(OFS_IRQ_SET, 32'h0);
    wr(OFS_IRQ_CLR, 32'h0);
    wr(OFS_IRQ_CLR, 32'h2);
    rd(OFS_IRQ_SET, 32'h5);
  endtask : t_ien

  task t_end();
    wr(OFS_SHORTCUT, 32'h1);
    ev(4'h8);
    chk("task", 1'h1, tsk);
    chk("end strobe", 1'h1, e_stb);
    chk("end channel", 8'ha5, e_ch);
    chk("irq", 1'h1, irq);
    wr(OFS_SHORTCUT, 32'h0);
    wr(OFS_END_FLAG, 32'h0);
    chk("irq", 1'h0, irq);
    ev(4'h8);
    chk("task", 1'h0, tsk);
    wr(OFS_END_FLAG, 32'h0);
  endtask : t_end

  task t_acq();
    ev(4'h4);
    chk("acq strobe", 1'h0, a_stb);
    chk("irq", 1'h1, irq);
    rd(OFS_ACQ_FLAG, 32'h1);
    wr(OFS_IRQ_CLR, 32'h4);
    chk("irq", 1'h0, irq);
    wr(OFS_ACQ_PUB, 32'h8000_0042);
    ev(4'h4);
    chk("acq strobe", 1'h1, a_stb);
    chk("acq channel", 8'h42, a_ch);
    wr(OFS_ACQ_FLAG, 32'h0);
  endtask : t_acq

  task t_rx(input logic [31:0] cfg);
    wr(OFS_RXEND_PUB, cfg);
    wr(OFS_IRQ_SET, 32'h2);
    ev(4'h2);
    ev(4'h1);
    ev(4'h1);
    chk("rx strobe", 1'h0, r_stb);
    ev(4'h1);
    chk("rx strobe", cfg[31], r_stb);
    chk("rx channel", 8'h11, r_ch);
    chk("irq", 1'h1, irq);
    ev(4'h1);
    chk("rx strobe", 1'h0, r_stb);
    wr(OFS_IRQ_CLR, 32'h7);
    chk("irq", 1'h0, irq);
    rd(OFS_IRQ_SET, 32'h0);
    wr(OFS_RXEND_FLAG, 32'h0);
  endtask : t_rx

  initial begin
    {resetn, reg_wr, reg_rd, ev_end, ev_acq, rx_start, rx_byte} = 7'h0;
    clk_en = 1'h1;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    rx_max = 16'h0003;
    repeat (4) @(posedge core_clk);
    resetn <= 1'h1;
    t_regs();
    t_hold();
    t_ien();
    t_end();
    t_acq();
    t_rx(32'h8000_0011);
    t_rx(32'h0000_0011);
    conclude();
  end
endmodule : ssei_regs_test
